/* src/drrc_pkg.sv */
package drrc_pkg;
	// mode register four fields
	localparam int MR4_SKIP_EN_POS   = 3;
	localparam int MR4_RANGE_SEL_POS = 2;
	// mode register three refresh rate field
	localparam int MR3_RATE_LSB      = 6;
	localparam int MR3_RATE_W        = 3;
	localparam int MR_DATA_W         = 18;
	localparam int MR_SEL_W          = 3;
	localparam logic [2:0] MR_SEL_THREE = 3'h3;
	localparam logic [2:0] MR_SEL_FOUR  = 3'h4;
	localparam logic [MR_DATA_W-1:0] MR_RESET_VALUE = 18'h00000;

	typedef enum logic [2:0] {
		DRRC_RATE_FIX1  = 3'b000,
		DRRC_RATE_FIX2  = 3'b001,
		DRRC_RATE_FIX4  = 3'b010,
		DRRC_RATE_RSV3  = 3'b011,
		DRRC_RATE_RSV4  = 3'b100,
		DRRC_RATE_OTF12 = 3'b101,
		DRRC_RATE_OTF14 = 3'b110,
		DRRC_RATE_RSV7  = 3'b111
	} drrc_rate_t;

	// internal refresh kind of one command
	typedef enum logic [1:0] {
		DRRC_KIND_1X   = 2'b00,
		DRRC_KIND_2X   = 2'b01,
		DRRC_KIND_4X   = 2'b10,
		DRRC_KIND_NONE = 2'b11
	} drrc_kind_t;

	// temperature bands of the case temperature
	typedef enum logic [1:0] {
		DRRC_TEMP_LE85  = 2'b00,
		DRRC_TEMP_LE95  = 2'b01,
		DRRC_TEMP_LE105 = 2'b10,
		DRRC_TEMP_LE125 = 2'b11
	} drrc_temp_t;

	// refresh intervals in ps, and cycles at 100 MHz
	localparam int CLK_PERIOD_PS   = 10000;
	localparam int REFI_BASE_PS    = 7800000;
	localparam int REFI_85_PS      = 3900000;
	localparam int REFI_95_PS      = 1950000;
	localparam int REFI_105_PS     = 975000;
	localparam int REFI_BASE_CYC   = REFI_BASE_PS / CLK_PERIOD_PS;
	localparam int REFI_85_CYC     = REFI_85_PS / CLK_PERIOD_PS;
	localparam int REFI_95_CYC     = REFI_95_PS / CLK_PERIOD_PS;
	localparam int REFI_105_CYC    = REFI_105_PS / CLK_PERIOD_PS;
	localparam int REFI_CNT_W      = 16;
	// skip gear: pass one in this many while cool
	localparam int SKIP_GEAR_NORMAL   = 2;
	localparam int SKIP_GEAR_EXTENDED = 2;
	localparam int GEAR_W             = 4;
endpackage

/* src/drrc_cmd_if.sv */
`timescale 1ns/10ps
interface drrc_cmd_if;
	import drrc_pkg::*;
	logic                 cke;
	logic                 cs_n;
	logic                 act_n;
	logic                 ras_n;
	logic                 cas_n;
	logic                 we_n;
	logic                 bg0;
	logic [MR_SEL_W-1:0]  mr_sel;
	logic [MR_DATA_W-1:0] mr_data;

	modport ctrl (output cke, cs_n, act_n, ras_n, cas_n, we_n, bg0, mr_sel, mr_data);
	modport dram (input cke, cs_n, act_n, ras_n, cas_n, we_n, bg0, mr_sel, mr_data);
endinterface

/* src/drrc_dram.sv */
`timescale 1ns/10ps
// What this block does
// - controller refreshes per temperature interval
// - range bit leaves disabled obligation unchanged
// - skip enable bit turns skipping on
// - range bit picks normal or extended
// - controller sets range to real temperature
// - accept all refreshes, skip at gear
// - internal rate follows case temperature
// - normal range skips below 85 C
// - extended range skips only at or below 85 C
// - extended range needs 3.9 us refresh
// - decode three-bit refresh rate field
// - fixed one set, otf two sets
// - program otf before otf refreshes
// - sample group bit with each refresh
// - bit low 1x, high 2x or 4x
// - 2x half, 4x quarter base interval
// - fixed modes take matching refresh types
// - refresh is cs ras cas low, we high
module drrc_dram
	import drrc_pkg::*;
#(
	parameter int GEAR_NORMAL   = SKIP_GEAR_NORMAL,
	parameter int GEAR_EXTENDED = SKIP_GEAR_EXTENDED
) (
	input  wire logic                 clk_i,
	input  wire logic                 reset_n_i,
	input  wire logic                 clk_en_i,
	drrc_cmd_if.dram                  cmd,
	input  wire drrc_pkg::drrc_temp_t temp_band_i,
	output logic                      skip_en_o,
	output logic                      range_ext_o,
	output drrc_pkg::drrc_rate_t      rate_mode_o,
	output logic                      rate_reserved_o,
	output logic                      refresh_run_o,
	output logic                      refresh_skip_o,
	output drrc_pkg::drrc_kind_t      refresh_kind_o
);
	import drrc_pkg::*;

	// gear counter cannot count past its width
	if (GEAR_NORMAL < 1 || GEAR_NORMAL >= 2**GEAR_W
	    || GEAR_EXTENDED < 1 || GEAR_EXTENDED >= 2**GEAR_W) begin : gear_check
		$error("skip gear out of range");
	end

	logic [MR_DATA_W-1:0] mr3_q;
	logic [MR_DATA_W-1:0] mr4_q;
	logic [GEAR_W-1:0]    gear_cnt_q;
	logic [GEAR_W-1:0]    gear_cnt_d;
	logic                 run_q;
	logic                 skip_q;
	drrc_kind_t           kind_q;

	wire is_cmd   = !cmd.cs_n && cmd.act_n;
	wire is_ref   = is_cmd && !cmd.ras_n && !cmd.cas_n && cmd.we_n;
	wire is_mrs   = is_cmd && !cmd.ras_n && !cmd.cas_n && !cmd.we_n;
	wire skip_en  = mr4_q[MR4_SKIP_EN_POS];
	wire range_ext = mr4_q[MR4_RANGE_SEL_POS];
	wire drrc_rate_t rate = drrc_rate_t'(mr3_q[MR3_RATE_LSB +: MR3_RATE_W]);
	wire rsv = (rate == DRRC_RATE_RSV3) || (rate == DRRC_RATE_RSV4) || (rate == DRRC_RATE_RSV7);
	wire [GEAR_W-1:0] gear = range_ext ? GEAR_W'(GEAR_EXTENDED) : GEAR_W'(GEAR_NORMAL);
	wire cool     = (temp_band_i == DRRC_TEMP_LE85);
	wire may_skip = skip_en && cool;
	wire gear_wrap = (gear_cnt_q >= gear - GEAR_W'(1));
	// pass one command per gear, others skipped
	wire do_skip  = may_skip && !gear_wrap;

	function automatic drrc_kind_t kind_of(input drrc_rate_t r, input logic bg);
		case (r)
			DRRC_RATE_FIX1:  kind_of = DRRC_KIND_1X;
			DRRC_RATE_FIX2:  kind_of = DRRC_KIND_2X;
			DRRC_RATE_FIX4:  kind_of = DRRC_KIND_4X;
			DRRC_RATE_OTF12: kind_of = bg ? DRRC_KIND_2X : DRRC_KIND_1X;
			DRRC_RATE_OTF14: kind_of = bg ? DRRC_KIND_4X : DRRC_KIND_1X;
			default:         kind_of = DRRC_KIND_NONE;
		endcase
	endfunction

	always_comb begin
		gear_cnt_d = gear_cnt_q;
		if (!may_skip)
			gear_cnt_d = '0;
		else if (is_ref)
			gear_cnt_d = gear_wrap ? '0 : gear_cnt_q + GEAR_W'(1);
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			mr3_q <= MR_RESET_VALUE;
			mr4_q <= MR_RESET_VALUE;
		end else if (clk_en_i && cmd.cke && is_mrs) begin
			if (cmd.mr_sel == MR_SEL_THREE)
				mr3_q <= cmd.mr_data;
			if (cmd.mr_sel == MR_SEL_FOUR)
				mr4_q <= cmd.mr_data;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			gear_cnt_q <= '0;
			run_q      <= 1'b0;
			skip_q     <= 1'b0;
			kind_q     <= DRRC_KIND_NONE;
		end else if (clk_en_i) begin
			gear_cnt_q <= cmd.cke ? gear_cnt_d : gear_cnt_q;
			run_q      <= cmd.cke && is_ref && !do_skip;
			skip_q     <= cmd.cke && is_ref && do_skip;
			if (cmd.cke && is_ref)
				kind_q <= kind_of(rate, cmd.bg0);
		end
	end

	assign skip_en_o       = skip_en;
	assign range_ext_o     = range_ext;
	assign rate_mode_o     = rate;
	assign rate_reserved_o = rsv;
	assign refresh_run_o   = run_q;
	assign refresh_skip_o  = skip_q;
	assign refresh_kind_o  = kind_q;
endmodule

/* src/drrc_ctrl.sv */
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/10ps
module drrc_ctrl
	import drrc_pkg::*;
#(
	parameter int REFI_BASE = REFI_BASE_CYC
) (
	input  wire logic                 clk_i,
	input  wire logic                 reset_n_i,
	input  wire logic                 clk_en_i,
	drrc_cmd_if.ctrl                  cmd,
	input  wire logic [3:0]           addr_i,
	input  wire logic [31:0]          wdata_i,
	input  wire logic                 wr_i,
	input  wire logic                 rd_i,
	output logic [31:0]               rdata_o
);
	import drrc_pkg::*;

	localparam logic [3:0] REG_CTRL   = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;

	// deepest divide is by 32, a smaller base would give a zero interval
	if (REFI_BASE < 32 || REFI_BASE >= 2**REFI_CNT_W) begin : refi_check
		$error("refresh interval out of range");
	end

	typedef enum logic [1:0] {
		DRRC_ST_IDLE = 2'b00,
		DRRC_ST_MR3  = 2'b01,
		DRRC_ST_MR4  = 2'b10,
		DRRC_ST_RUN  = 2'b11
	} drrc_state_t;

	drrc_state_t             st_q;
	logic [31:0]             ctrl_q;
	logic [31:0]             rdata_q;
	logic [REFI_CNT_W-1:0]   cnt_q;
	logic [15:0]             ref_cnt_q;
	logic [1:0]              otf_tog_q;
	logic                    issue_mrs_q;
	logic                    issue_ref_q;
	logic [MR_SEL_W-1:0]     sel_q;
	logic [MR_DATA_W-1:0]    mrd_q;
	logic                    bg0_q;
	logic [6:0]              cfg_q;

	// ctrl: [0] go, [3:1] rate, [4] skip en, [5] range ext, [7:6] temp band
	wire       go        = ctrl_q[0];
	wire [2:0] rate_raw  = ctrl_q[3:1];
	// reserved codes fall back to fixed 1x
	wire [2:0] rate      = (rate_raw == 3'h3 || rate_raw == 3'h4 || rate_raw == 3'h7)
	                       ? 3'h0 : rate_raw;
	wire       skip_en   = ctrl_q[4];
	// range follows hotter band when enabled
	wire       range_ext = ctrl_q[5] || (skip_en && ctrl_q[7:6] != 2'b00);
	wire [1:0] band      = ctrl_q[7:6];
	wire       per_command_rate_select       = rate[2];
	// otf mode alternates fast and base refreshes
	wire       fast      = per_command_rate_select ? otf_tog_q[0] : 1'b1;
	wire [1:0] shift_raw = (rate == 3'h1 || rate == 3'h5) ? 2'd1 :
	                       (rate == 3'h2 || rate == 3'h6) ? 2'd2 : 2'd0;
	wire [1:0] shift     = fast ? shift_raw : 2'd0;

	function automatic logic [REFI_CNT_W-1:0] interval(input logic [1:0] b, input logic [1:0] s,
	                                                   input logic ext);
		logic [REFI_CNT_W-1:0] base;
		base = REFI_CNT_W'(REFI_BASE);
		if (b == 2'b11)
			base = base >> 3;
		else if (b == 2'b10)
			base = base >> 2;
		else if (b == 2'b01 || (ext && skip_en))
			base = base >> 1;
		interval = base >> s;
	endfunction

	wire [REFI_CNT_W-1:0] limit = interval(band, shift, range_ext);
	wire ref_due = (st_q == DRRC_ST_RUN) && (cnt_q >= limit - REFI_CNT_W'(1));
	// changed settings written before further refreshes
	wire cfg_chg = (ctrl_q[7:1] != cfg_q);

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ctrl_q  <= 32'h00000000;
			rdata_q <= 32'h00000000;
		end else if (clk_en_i) begin
			if (wr_i && addr_i == REG_CTRL)
				ctrl_q <= {24'h000000, wdata_i[7:0]};
			if (rd_i)
				rdata_q <= (addr_i == REG_CTRL) ? ctrl_q :
				           (addr_i == REG_STATUS) ? {14'h0000, st_q, ref_cnt_q} : 32'h00000000;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_q        <= DRRC_ST_IDLE;
			cnt_q       <= '0;
			ref_cnt_q   <= 16'h0000;
			otf_tog_q   <= 2'b00;
			issue_mrs_q <= 1'b0;
			issue_ref_q <= 1'b0;
			sel_q       <= 3'h0;
			mrd_q       <= '0;
			bg0_q       <= 1'b0;
			cfg_q       <= 7'h00;
		end else if (clk_en_i) begin
			issue_mrs_q <= 1'b0;
			issue_ref_q <= 1'b0;
			case (st_q)
				DRRC_ST_IDLE: if (go) st_q <= DRRC_ST_MR3;
				DRRC_ST_MR3: begin
					issue_mrs_q <= 1'b1;
					sel_q       <= MR_SEL_THREE;
					cfg_q       <= ctrl_q[7:1];
					mrd_q       <= MR_DATA_W'({rate, 6'h00});
					st_q        <= DRRC_ST_MR4;
				end
				DRRC_ST_MR4: begin
					issue_mrs_q <= 1'b1;
					sel_q       <= MR_SEL_FOUR;
					mrd_q       <= MR_DATA_W'({skip_en, range_ext, 2'b00});
					cnt_q       <= '0;
					st_q        <= DRRC_ST_RUN;
				end
				DRRC_ST_RUN: begin
					if (!go) begin
						st_q <= DRRC_ST_IDLE;
					end else if (cfg_chg) begin
						st_q <= DRRC_ST_MR3;
					end else if (ref_due) begin
						issue_ref_q <= 1'b1;
						bg0_q       <= per_command_rate_select && fast;
						cnt_q       <= '0;
						ref_cnt_q   <= ref_cnt_q + 16'h0001;
						otf_tog_q   <= otf_tog_q + 2'b01;
					end else begin
						cnt_q <= cnt_q + REFI_CNT_W'(1);
					end
				end
				default: st_q <= DRRC_ST_IDLE;
			endcase
		end
	end

	assign cmd.cke     = 1'b1;
	assign cmd.cs_n    = !(issue_mrs_q || issue_ref_q);
	assign cmd.act_n   = 1'b1;
	assign cmd.ras_n   = !(issue_mrs_q || issue_ref_q);
	assign cmd.cas_n   = !(issue_mrs_q || issue_ref_q);
	assign cmd.we_n    = !issue_mrs_q;
	assign cmd.bg0     = bg0_q;
	assign cmd.mr_sel  = sel_q;
	assign cmd.mr_data = mrd_q;
	assign rdata_o     = rdata_q;
endmodule

/* bench/drrc_chk.sv */
`timescale 1ns/10ps
module drrc_chk (
	input wire logic                          clk_i,
	input wire logic                          reset_n_i,
	input wire logic                          clk_en_i,
	input wire logic                          cke,
	input wire logic                          cs_n,
	input wire logic                          act_n,
	input wire logic                          ras_n,
	input wire logic                          cas_n,
	input wire logic                          we_n,
	input wire logic                          bg0,
	input wire logic [drrc_pkg::MR_SEL_W-1:0] mr_sel,
	input wire logic [drrc_pkg::MR_DATA_W-1:0] mr_data,
	input wire drrc_pkg::drrc_temp_t          temp_band_i,
	input wire logic                          skip_en_o,
	input wire logic                          range_ext_o,
	input wire drrc_pkg::drrc_rate_t          rate_mode_o,
	input wire logic                          rate_reserved_o,
	input wire logic                          refresh_run_o,
	input wire logic                          refresh_skip_o,
	input wire drrc_pkg::drrc_kind_t          refresh_kind_o
);
	import drrc_pkg::*;
	wire cmd_v = clk_en_i & cke & ~cs_n & act_n & ~ras_n & ~cas_n;
	wire ref_c = cmd_v & we_n;
	wire mrw   = cmd_v & ~we_n;
	wire per_command_rate_select   = (rate_mode_o == DRRC_RATE_OTF12) || (rate_mode_o == DRRC_RATE_OTF14);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	AST_ONE_ANSWER: assert property (ref_c |=> refresh_run_o != refresh_skip_o)
		else $error("refresh not answered by exactly one pulse");
	AST_NO_EXTRA: assert property (clk_en_i && !ref_c
		|=> !refresh_run_o && !refresh_skip_o)
		else $error("refresh pulse without command");
	AST_SKIP_OFF: assert property (ref_c && !skip_en_o |=> refresh_run_o)
		else $error("refresh skipped with skipping off");
	AST_HOT_RUN: assert property (ref_c && temp_band_i != DRRC_TEMP_LE85
		|=> refresh_run_o)
		else $error("refresh skipped while hot");
	AST_FIXED: assert property (ref_c && !rate_mode_o[2] && !rate_reserved_o
		|=> refresh_kind_o == $past(rate_mode_o[1:0]))
		else $error("fixed mode kind wrong");
	AST_OTF_LOW: assert property (ref_c && per_command_rate_select && !bg0
		|=> refresh_kind_o == DRRC_KIND_1X)
		else $error("low group bit not 1x");
	AST_OTF_HIGH: assert property (ref_c && per_command_rate_select && bg0
		|=> refresh_kind_o == ($past(rate_mode_o[0]) ? DRRC_KIND_2X : DRRC_KIND_4X))
		else $error("high group bit kind wrong");
	AST_MR4: assert property (mrw && mr_sel == MR_SEL_FOUR
		|=> skip_en_o == $past(mr_data[3]) && range_ext_o == $past(mr_data[2]))
		else $error("mode four fields not taken");
	AST_MR3: assert property (mrw && mr_sel == MR_SEL_THREE
		|=> rate_mode_o == $past(mr_data[8:6]))
		else $error("rate field not taken");
	AST_NO_RSV: assert property (mrw && mr_sel == MR_SEL_THREE
		|-> mr_data[8:6] inside {3'h0, 3'h1, 3'h2, 3'h5, 3'h6})
		else $error("reserved rate code sent");
	AST_KIND_HOLD: assert property (!ref_c |=> $stable(refresh_kind_o))
		else $error("kind changed without refresh");
	AST_OTF_PROGRAMMED: assert property (ref_c && bg0 |-> per_command_rate_select)
		else $error("per command rate refresh before mode write");
endmodule

/* bench/drrc_tb_top.sv */
`timescale 1ns/10ps
module drrc_tb_top;
	import drrc_pkg::*;
	localparam int BASE = 32;
	logic        clk_en    = 1'b1;
	logic        clk_i     = 1'b0;
	logic        reset_n_i = 1'b0;
	logic [3:0]  addr      = 4'h0;
	logic [31:0] wdata     = 32'h0;
	logic        wr        = 1'b0;
	logic        rd        = 1'b0;
	logic [31:0] rdata;
	drrc_temp_t  temp_band = DRRC_TEMP_LE85;
	logic        skip_en, range_ext, rate_rsv, run, skip;
	drrc_rate_t  rate_mode;
	drrc_kind_t  kind;
	int          fail_count = 0;
	int          checked    = 0;
	drrc_cmd_if cmd_bus ();
	wire ref_c = cmd_bus.cke & ~cmd_bus.cs_n & cmd_bus.act_n & ~cmd_bus.ras_n
		& ~cmd_bus.cas_n & cmd_bus.we_n;
	drrc_ctrl #(.REFI_BASE(BASE)) drrc_ctrl_inst (.clk_i(clk_i), .reset_n_i(reset_n_i),
		.clk_en_i(clk_en), .cmd(cmd_bus.ctrl), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
		.rd_i(rd), .rdata_o(rdata));
	drrc_dram drrc_dram_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en),
		.cmd(cmd_bus.dram), .temp_band_i(temp_band), .skip_en_o(skip_en),
		.range_ext_o(range_ext), .rate_mode_o(rate_mode), .rate_reserved_o(rate_rsv),
		.refresh_run_o(run), .refresh_skip_o(skip), .refresh_kind_o(kind));
	drrc_chk drrc_chk_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en),
		.cke(cmd_bus.cke), .cs_n(cmd_bus.cs_n), .act_n(cmd_bus.act_n), .ras_n(cmd_bus.ras_n),
		.cas_n(cmd_bus.cas_n), .we_n(cmd_bus.we_n), .bg0(cmd_bus.bg0), .mr_sel(cmd_bus.mr_sel),
		.mr_data(cmd_bus.mr_data), .temp_band_i(temp_band), .skip_en_o(skip_en),
		.range_ext_o(range_ext), .rate_mode_o(rate_mode), .rate_reserved_o(rate_rsv),
		.refresh_run_o(run), .refresh_skip_o(skip), .refresh_kind_o(kind));
	task automatic end_of_test();
		if (fail_count == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_i);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_i);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	// cycles to next refresh command, outputs settled on return
	task automatic wait_ref(output int gap, output logic b);
		gap = 0;
		do begin
			@(negedge clk_i);
			gap++;
		end while (!ref_c && gap < 400);
		if (gap >= 400) chk(32'h0, 32'h1);
		b = cmd_bus.bg0;
		@(posedge clk_i);
		#1;
	endtask
	task automatic cfg(input logic [31:0] d);
		int g;
		logic b;
		wr_reg(4'h0, d);
		wait_ref(g, b);
		wait_ref(g, b);
	endtask
	task automatic t_fixed();
		int g;
		logic b;
		for (int r = 0; r < 3; r++) begin
			cfg(32'(r * 2 + 1));
			wait_ref(g, b);
			chk(g, BASE >> r);
			chk(rate_mode, r);
			chk(kind, r);
		end
	endtask
	task automatic t_otf();
		int g;
		int hi;
		logic b;
		for (int r = 5; r < 7; r++) begin
			cfg(32'(r * 2 + 1));
			hi = 0;
			for (int i = 0; i < 4; i++) begin
				wait_ref(g, b);
				hi += b;
				chk(kind, b ? (r == 5 ? DRRC_KIND_2X : DRRC_KIND_4X) : DRRC_KIND_1X);
			end
			chk(hi, 2);
			chk(rate_mode, r);
		end
	endtask
	task automatic t_rsv();
		int rs[3] = '{3, 4, 7};
		int g;
		logic b;
		for (int i = 0; i < 3; i++) begin
			cfg(32'(rs[i] * 2 + 1));
			chk(rate_mode, DRRC_RATE_FIX1);
			chk(rate_rsv, 1'b0);
		end
	endtask
	// skip on/off, range, hot band
	task automatic t_skip();
		logic [31:0] dt[4] = '{32'h11, 32'h31, 32'h51, 32'h21};
		int bd[4] = '{0, 0, 1, 0};
		int rn[4] = '{2, 2, 4, 4};
		int gp[4] = '{BASE, BASE / 2, BASE / 2, BASE};
		int rx[4] = '{0, 1, 1, 1};
		int g;
		int n;
		logic b;
		for (int i = 0; i < 4; i++) begin
			temp_band <= drrc_temp_t'(bd[i]);
			cfg(dt[i]);
			n = 0;
			for (int k = 0; k < 4; k++) begin
				wait_ref(g, b);
				n += run;
			end
			chk(n, rn[i]);
			chk(g, gp[i]);
			chk(skip_en, dt[i][4]);
			chk(range_ext, rx[i]);
		end
		temp_band <= DRRC_TEMP_LE85;
	endtask
	task automatic t_regs();
		logic [31:0] a;
		logic [31:0] c;
		int g;
		logic b;
		rd_reg(4'h4, a);
		wait_ref(g, b);
		rd_reg(4'h4, c);
		chk(32'(c[15:0] - a[15:0]), 32'h1);
		rd_reg(4'hc, c);
		chk(c, 32'h0);
	endtask
	// low clock enable stops the refresh count
	task automatic t_freeze();
		logic [31:0] a;
		logic [31:0] c;
		rd_reg(4'h4, a);
		@(posedge clk_i);
		clk_en <= 1'b0;
		repeat (100) @(posedge clk_i);
		clk_en <= 1'b1;
		rd_reg(4'h4, c);
		chk(32'(c[15:0] - a[15:0] <= 16'h0001), 32'h1);
	endtask
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	initial begin
		repeat (12) @(posedge clk_i);
		reset_n_i <= 1'b1;
		t_fixed();
		t_otf();
		t_rsv();
		t_skip();
		t_regs();
		t_freeze();
		end_of_test();
	end
	initial begin
		#300000;
		fail_count++;
		end_of_test();
	end
endmodule
